// >>> dac_port_pkg.sv
package dac_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Channel and code geometry.
  localparam int NUM_CH  = 4;
  localparam int CODE_W  = 10;
  localparam int PWR_W   = 2;
  localparam int CODE_LSB = 6;   // Code sits left-justified in the 16-bit word.

  ////////////////////////////////////////////////////////////////////////////
  // Slave address: five fixed upper bits, two strapped low bits.
  localparam logic [4:0] ADDR_FIXED = 5'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Command nibble codes (upper half of the command byte).
  localparam logic [3:0] CMD_NOP     = 4'h0;
  localparam logic [3:0] CMD_WR_IN   = 4'h1;
  localparam logic [3:0] CMD_UPDATE  = 4'h2;
  localparam logic [3:0] CMD_WR_UPD  = 4'h3;
  localparam logic [3:0] CMD_POWER   = 4'h4;
  localparam logic [3:0] CMD_MASK    = 4'h5;
  localparam logic [3:0] CMD_SWRESET = 4'h6;
  localparam logic [3:0] CMD_REFSET  = 4'h7;

  // Field positions inside the command byte.
  localparam int CMD_HI = 7;
  localparam int CMD_LO = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Channel power field encodings.
  localparam logic [1:0] PWR_NORMAL   = 2'h0;
  localparam logic [1:0] PWR_1K       = 2'h1;
  localparam logic [1:0] PWR_100K     = 2'h2;
  localparam logic [1:0] PWR_TRISTATE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and byte bookkeeping.
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [7:0] PWR_RESET  = 8'h00;
  localparam logic [3:0] AMP_RESET  = 4'hf;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] BYTE_CMD   = 2'h0;
  localparam logic [1:0] BYTE_HI    = 2'h1;
  localparam logic [1:0] BYTE_LO    = 2'h2;
  localparam logic [1:0] CH_A       = 2'h0;

  // Protocol engine states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE      = 7'h01,
    ST_ADDR      = 7'h02,
    ST_ADDR_ACK  = 7'h04,
    ST_WDATA     = 7'h08,
    ST_WDATA_ACK = 7'h10,
    ST_RDATA     = 7'h20,
    ST_RDATA_ACK = 7'h40
  } port_state_e;

endpackage : dac_port_pkg

// >>> quad_dac_serial_command_port.sv
`timescale 1ns/1ps
module quad_dac_serial_command_port
  import dac_port_pkg::*;
(
  input  wire logic                           ref_clk,           // System clock, 200 MHz.
  input  wire logic                           rst,               // Reset, synchronous except in the serial capture.
  input  wire logic                           sclClk,            // Serial clock pin.
  input  wire logic                           sdaIn,             // Serial data pin level.
  output logic                                sdaOut,            // Level driven when enabled.
  output logic                                sdaOe,             // High while pulling data low.
  input  wire logic                           addressStrapHigh,  // Strap for address bit 1.
  input  wire logic                           addressStrapLow,   // Strap for address bit 0.
  output logic [NUM_CH-1:0][CODE_W-1:0]       dacCode,           // Output register codes.
  output logic [NUM_CH-1:0][CODE_W-1:0]       inputCode,         // Input register codes.
  output logic [NUM_CH*PWR_W-1:0]             powerMode,         // Two-bit mode per channel.
  output logic [NUM_CH-1:0]                   ampConnect,        // Output fed by amplifier.
  output logic [NUM_CH-1:0]                   term1k,            // Output tied low by 1 kOhm.
  output logic [NUM_CH-1:0]                   term100k,          // Output tied low by 100 kOhm.
  output logic                                busSelected        // Addressed in current transfer.
);

  ////////////////////////////////////////////////////////////////////////////
  // State record.

  typedef struct packed {
    port_state_e                 state;
    logic [2:0]                  bitCnt;
    logic [7:0]                  shReg;
    logic [1:0]                  byteIdx;
    logic [7:0]                  cmdByte;
    logic [7:0]                  dataHi;
    logic [7:0]                  txShift;
    logic                        rdMode;
    logic                        ackOn;
    logic                        pending;
    logic                        reload;
    logic                        rdLow;
    logic [1:0]                  rdPtr;
    logic                        sdaOe;
    logic                        sclPrev;
    logic                        sdaPrev;
    logic                        togPrev;
    logic [NUM_CH-1:0][CODE_W-1:0] inCode;
    logic [NUM_CH-1:0][CODE_W-1:0] outCode;
    logic [NUM_CH*PWR_W-1:0]     pwr;
    logic [NUM_CH-1:0]           ampOn;
    logic [NUM_CH-1:0]           t1k;
    logic [NUM_CH-1:0]           t100k;
  } port_s;

  localparam port_s PORT_RESET = '{
    state:   ST_IDLE,
    inCode:  {NUM_CH{CODE_RESET}},
    outCode: {NUM_CH{CODE_RESET}},
    pwr:     PWR_RESET,
    ampOn:   AMP_RESET,
    default: '0
  };

  port_s portReg;
  port_s portNext;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Readback starts at the single selected channel; a multi-channel or empty
  // mask falls back to channel A.
  function automatic logic [1:0] readStart(input logic [3:0] sel);
    logic [1:0] ch;
    ch = CH_A;
    if (sel == 4'h2) begin
      ch = 2'h1;
    end else if (sel == 4'h4) begin
      ch = 2'h2;
    end else if (sel == 4'h8) begin
      ch = 2'h3;
    end
    return ch;
  endfunction : readStart

  // One byte of a channel's input register, left-justified with zero padding.
  function automatic logic [7:0] readByte(input logic [NUM_CH-1:0][CODE_W-1:0] codes,
                                          input logic [1:0] ch,
                                          input logic       low);
    logic [15:0] word;
    word = {codes[ch], 6'h00};
    return low ? word[7:0] : word[15:8];
  endfunction : readByte

  // Address check: fixed upper bits plus the strapped pair.
  function automatic logic addrMatch(input logic [6:0] addr,
                                     input logic       hiStrap,
                                     input logic       loStrap);
    return addr == {ADDR_FIXED, hiStrap, loStrap};
  endfunction : addrMatch

  ////////////////////////////////////////////////////////////////////////////
  // Crossings from the pins and from the serial clock domain.

  logic       capTog;
  logic       capBit;
  logic [4:0] pinSync;

  // The link-side flop samples data at each rising serial clock edge.
  scl_bit_capture u_capture (
    .sclClk    (sclClk),
    .rst       (rst),
    .sdaIn     (sdaIn),
    .bitToggle (capTog),
    .bitValue  (capBit)
  );

  // Pins and the capture toggle each pass two flops before any decision.
  sync_2ff #(
    .WIDTH (5)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn ({addressStrapHigh, addressStrapLow, capTog, sclClk, sdaIn}),
    .syncOut (pinSync)
  );

  logic sclS;
  logic sdaS;
  logic togS;
  logic strapHiS;
  logic strapLoS;
  assign {strapHiS, strapLoS, togS, sclS, sdaS} = pinSync;

  ////////////////////////////////////////////////////////////////////////////
  // Bus events.

  logic       startEv;
  logic       stopEv;
  logic       sclFall;
  logic       bitEv;
  logic [7:0] rxByte;
  logic [3:0] cmdCode;
  logic [3:0] chanSel;
  logic [9:0] frameCode;
  logic [15:0] frameWord;

  // Start and stop are data edges while the clock stays high; the capture
  // value is only read after its toggle has been synchronised, so it is
  // settled by then.
  always_comb begin
    startEv   = sclS & portReg.sclPrev & portReg.sdaPrev & ~sdaS;
    stopEv    = sclS & portReg.sclPrev & ~portReg.sdaPrev & sdaS;
    sclFall   = portReg.sclPrev & ~sclS;
    bitEv     = togS ^ portReg.togPrev;
    rxByte    = {portReg.shReg[6:0], capBit};
    cmdCode   = portReg.cmdByte[CMD_HI:CMD_LO];
    chanSel   = portReg.cmdByte[SEL_HI:SEL_LO];
    frameWord = {portReg.dataHi, rxByte};
    frameCode = frameWord[15:CODE_LSB];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine and command execution.

  // The data line is only ever changed on a falling clock edge, so the
  // engine never creates a false start or stop while the master holds the
  // clock high.
  always_comb begin
    portNext         = portReg;
    portNext.sclPrev = sclS;
    portNext.sdaPrev = sdaS;
    portNext.togPrev = togS;

    if (startEv) begin
      // A repeated start keeps the readback pointer for the read phase.
      portNext.state   = ST_ADDR;
      portNext.bitCnt  = 3'h0;
      portNext.ackOn   = 1'b0;
      portNext.pending = 1'b0;
      portNext.reload  = 1'b0;
      portNext.sdaOe   = 1'b0;
    end else if (stopEv) begin
      portNext.state   = ST_IDLE;
      portNext.ackOn   = 1'b0;
      portNext.pending = 1'b0;
      portNext.reload  = 1'b0;
      portNext.sdaOe   = 1'b0;
    end else begin
      case (portReg.state)
        ST_ADDR: begin
          if (bitEv) begin
            portNext.shReg  = rxByte;
            portNext.bitCnt = portReg.bitCnt + 3'h1;
            if (portReg.bitCnt == LAST_BIT) begin
              portNext.rdMode  = rxByte[0];
              portNext.byteIdx = BYTE_CMD;
              portNext.ackOn   = 1'b0;
              if (addrMatch(rxByte[7:1], strapHiS, strapLoS)) begin
                portNext.state = ST_ADDR_ACK;
              end else begin
                portNext.state = ST_IDLE;
              end
            end
          end
        end

        ST_ADDR_ACK, ST_WDATA_ACK: begin
          if (sclFall) begin
            if (!portReg.ackOn) begin
              portNext.ackOn = 1'b1;
              portNext.sdaOe = 1'b1;
            end else begin
              portNext.ackOn = 1'b0;
              portNext.sdaOe = 1'b0;
              if (portReg.state == ST_ADDR_ACK && portReg.rdMode) begin
                portNext.rdLow   = 1'b0;
                portNext.txShift = readByte(portReg.inCode, portReg.rdPtr, 1'b0);
                portNext.sdaOe   = ~portNext.txShift[7];
                portNext.state   = ST_RDATA;
              end else begin
                portNext.state = ST_WDATA;
              end
            end
          end
        end

        ST_WDATA: begin
          if (bitEv) begin
            portNext.shReg  = rxByte;
            portNext.bitCnt = portReg.bitCnt + 3'h1;
            if (portReg.bitCnt == LAST_BIT) begin
              portNext.state = ST_WDATA_ACK;
              portNext.ackOn = 1'b0;
              if (portReg.byteIdx == BYTE_CMD) begin
                portNext.cmdByte = rxByte;
                portNext.rdPtr   = readStart(rxByte[SEL_HI:SEL_LO]);
                portNext.rdLow   = 1'b0;
                portNext.byteIdx = BYTE_HI;
              end else if (portReg.byteIdx == BYTE_HI) begin
                portNext.dataHi  = rxByte;
                portNext.byteIdx = BYTE_LO;
              end else begin
                portNext.byteIdx = BYTE_CMD;
                // The frame is complete: act on it, channel by channel.
                case (cmdCode)
                  CMD_WR_IN: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                      if (chanSel[i]) begin
                        portNext.inCode[i] = frameCode;
                      end
                    end
                  end
                  CMD_UPDATE: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                      if (chanSel[i]) begin
                        portNext.outCode[i] = portReg.inCode[i];
                      end
                    end
                  end
                  CMD_WR_UPD: begin
                    // Output registers load regardless of the load pin and
                    // of the channel's power mode.
                    for (int i = 0; i < NUM_CH; i++) begin
                      if (chanSel[i]) begin
                        portNext.inCode[i]  = frameCode;
                        portNext.outCode[i] = frameCode;
                      end
                    end
                  end
                  CMD_POWER: begin
                    portNext.pwr = rxByte;
                  end
                  CMD_SWRESET: begin
                    portNext.inCode  = {NUM_CH{CODE_RESET}};
                    portNext.outCode = {NUM_CH{CODE_RESET}};
                    portNext.pwr     = PWR_RESET;
                    portNext.rdPtr   = CH_A;
                  end
                  default: begin
                    // No operation, mask, reference and reserved codes.
                  end
                endcase
              end
            end
          end
        end

        ST_RDATA: begin
          if (bitEv) begin
            portNext.bitCnt  = portReg.bitCnt + 3'h1;
            portNext.pending = 1'b1;
          end else if (sclFall && portReg.pending) begin
            portNext.pending = 1'b0;
            if (portReg.bitCnt == 3'h0) begin
              // All eight bits gone: free the line for the master's answer.
              portNext.sdaOe = 1'b0;
              portNext.state = ST_RDATA_ACK;
            end else begin
              portNext.txShift = {portReg.txShift[6:0], 1'b0};
              portNext.sdaOe   = ~portReg.txShift[6];
            end
          end
        end

        ST_RDATA_ACK: begin
          if (bitEv) begin
            if (!capBit) begin
              portNext.reload = 1'b1;
              if (!portReg.rdLow) begin
                portNext.rdLow = 1'b1;
              end else begin
                portNext.rdLow = 1'b0;
                portNext.rdPtr = portReg.rdPtr + 2'h1;
              end
            end else begin
              // Not acknowledged: stay off the line until the stop.
              portNext.state = ST_IDLE;
            end
          end else if (sclFall && portReg.reload) begin
            portNext.reload  = 1'b0;
            portNext.txShift = readByte(portReg.inCode, portReg.rdPtr, portReg.rdLow);
            portNext.sdaOe   = ~portNext.txShift[7];
            portNext.state   = ST_RDATA;
          end
        end

        default: begin
          // Idle: wait for a start condition.
        end
      endcase
    end

    // Output stage switches follow the stored power fields; the codes
    // themselves are untouched, so leaving power-down restores them.
    for (int i = 0; i < NUM_CH; i++) begin
      portNext.ampOn[i] = portNext.pwr[i*PWR_W +: PWR_W] == PWR_NORMAL;
      portNext.t1k[i]   = portNext.pwr[i*PWR_W +: PWR_W] == PWR_1K;
      portNext.t100k[i] = portNext.pwr[i*PWR_W +: PWR_W] == PWR_100K;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portReg <= PORT_RESET;
    end else begin
      portReg <= portNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from the state record except sdaOut, which is tied low.

  assign sdaOut      = 1'b0;
  assign sdaOe       = portReg.sdaOe;
  assign dacCode     = portReg.outCode;
  assign inputCode   = portReg.inCode;
  assign powerMode   = portReg.pwr;
  assign ampConnect  = portReg.ampOn;
  assign term1k      = portReg.t1k;
  assign term100k    = portReg.t100k;
  assign busSelected = portReg.state != ST_IDLE && portReg.state != ST_ADDR;

endmodule : quad_dac_serial_command_port

// >>> quad_dac_serial_command_port_properties.sv
`timescale 1ns/1ps
module quad_dac_serial_command_port_properties
  import dac_port_pkg::*;
(
  input wire logic                            ref_clk,           // Clock.
  input wire logic                            rst,               // Reset.
  input wire logic                            sclClk,            // Serial clock.
  input wire logic                            sdaIn,             // Data wire.
  input wire logic                            sdaOut,            // Drive level.
  input wire logic                            sdaOe,             // Pull enable.
  input wire logic                            addressStrapHigh,  // Strap 1.
  input wire logic                            addressStrapLow,   // Strap 0.
  input wire logic [NUM_CH-1:0][CODE_W-1:0]   dacCode,           // Output codes.
  input wire logic [NUM_CH-1:0][CODE_W-1:0]   inputCode,         // Input codes.
  input wire logic [NUM_CH*PWR_W-1:0]         powerMode,         // Modes.
  input wire logic [NUM_CH-1:0]               ampConnect,        // Amplifier.
  input wire logic [NUM_CH-1:0]               term1k,            // 1 kOhm.
  input wire logic [NUM_CH-1:0]               term100k,          // 100 kOhm.
  input wire logic                            busSelected        // Addressed.
);
  logic [NUM_CH-1:0] modeZero;
  logic [NUM_CH-1:0] mode1k;
  logic [NUM_CH-1:0] mode100k;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Expected output path per channel, decoded from the mode fields.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      modeZero[i] = powerMode[2*i+:2] == PWR_NORMAL;
      mode1k[i]   = powerMode[2*i+:2] == PWR_1K;
      mode100k[i] = powerMode[2*i+:2] == PWR_100K;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two quiet samples let a registered decode catch up with the mode.
  sequence modeSettled;
    $stable(powerMode) ##1 $stable(powerMode);
  endsequence

  sequence sclHeld;
    sclClk ##1 sclClk;
  endsequence

  ampFollow_a: assert property (modeSettled |-> ampConnect == modeZero)
    else $error("amplifier path wrong for mode");
  termLow_a: assert property (modeSettled |-> term1k == mode1k)
    else $error("1k termination wrong for mode");
  termHigh_a: assert property (modeSettled |-> term100k == mode100k)
    else $error("100k termination wrong for mode");
  ackHold_a: assert property (sclHeld |-> $stable(sdaOe))
    else $error("data drive moved while clock high");
  ackRise_a: assert property ($rose(sdaOe) |-> !sclClk && $past(sclClk, 2) == 1'b0)
    else $error("data drive rose outside clock low");
  pullOnly_a: assert property (sdaOut == 1'b0)
    else $error("data drive level not low");
  frameEdge_a: assert property (!$stable({dacCode, inputCode, powerMode}) |-> sclClk)
    else $error("registers changed away from a frame edge");

  // An output register only ever takes the input register's value.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    codeCopy_a: assert property (!$stable(dacCode[i]) |-> dacCode[i] == inputCode[i])
      else $error("output code differs from input code");
  end
endmodule : quad_dac_serial_command_port_properties

// >>> quad_dac_serial_command_port_tb.sv
`timescale 1ns/1ps
module quad_dac_serial_command_port_tb
  import dac_port_pkg::*;
;
  localparam time D = 1ns;
  logic                          ref_clk = 1'b0;
  logic                          rst = 1'b0;
  logic                          strapHi = 1'b0;
  logic                          strapLo = 1'b0;
  wire logic                     sclClk, drvLow, sdaOut, sdaOe, busSelected, sdaWire;
  wire logic [3:0][9:0]          dacCode, inputCode;
  wire logic [7:0]               powerMode;
  wire logic [3:0]               ampConnect, term1k, term100k;
  logic [3:0][9:0]               expIn = '0;
  logic [3:0][9:0]               expDac = '0;
  logic [7:0]                    expPwr = PWR_RESET;
  logic [8:0]                    busQ[$];
  logic [92:0]                   stateQ[$];
  logic [8:0]                    gotBus;
  logic [31:0]                   seed = 32'd51786;
  logic [31:0]                   r;
  int                            mismatches = 0;
  int                            check_count = 0;
  event                          busEv, stateEv;

  always #2.5 ref_clk = ~ref_clk;
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & !drvLow;

  quad_dac_serial_command_port dut_u (.ref_clk(ref_clk), .rst(rst), .sclClk(sclClk),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapHigh(strapHi),
    .addressStrapLow(strapLo), .dacCode(dacCode), .inputCode(inputCode),
    .powerMode(powerMode), .ampConnect(ampConnect), .term1k(term1k), .term100k(term100k),
    .busSelected(busSelected));
  two_wire_master_model mdl (.sclClk(sclClk), .sdaDrvLow(drvLow), .sdaWire(sdaWire));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp(string what, logic [92:0] e, logic [92:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  // Watchers pair each result with the oldest note left by the driver.
  always @(busEv) cmp("bus unit", busQ.pop_front(), gotBus);
  always @(stateEv) cmp("registers", stateQ.pop_front(),
                        {dacCode, inputCode, powerMode, ampConnect, busSelected});

  task automatic busByte(logic [7:0] tx, logic ackIn, logic [8:0] e);
    logic [7:0] rx;
    logic       ack;
    busQ.push_back(e);
    mdl.xfer(tx, ackIn, rx, ack);
    gotBus = {rx, ack};
    ->busEv;
  endtask : busByte

  // The device must acknowledge and leave the master's bits untouched.
  task automatic wb(logic [7:0] b);
    busByte(b, 1'b1, {b, 1'b0});
  endtask : wb

  // After a stop the block must be idle and each amplifier follow its mode.
  task automatic chkState();
    logic [3:0] expAmp;
    for (int i = 0; i < NUM_CH; i++) expAmp[i] = expPwr[2*i+:2] == PWR_NORMAL;
    repeat (4) @(posedge ref_clk);
    #D stateQ.push_back({expDac, expIn, expPwr, expAmp, 1'b0});
    ->stateEv;
  endtask : chkState

  task automatic wr(logic [7:0] cmd, logic [15:0] w);
    mdl.start();
    wb({ADDR_FIXED, strapHi, strapLo, 1'b0});
    wb(cmd);
    wb(w[15:8]);
    wb(w[7:0]);
    mdl.stop();
    for (int i = 0; i < NUM_CH; i++) begin
      if (cmd[i] && cmd[7:4] inside {CMD_WR_IN, CMD_WR_UPD}) expIn[i] = w[15:6];
      if (cmd[i] && cmd[7:4] inside {CMD_UPDATE, CMD_WR_UPD}) expDac[i] = expIn[i];
    end
    if (cmd[7:4] == CMD_POWER) expPwr = w[7:0];
    if (cmd[7:4] == CMD_SWRESET) {expIn, expDac, expPwr} = '0;
    chkState();
  endtask : wr

  // Readback streams input registers, high byte first, wrapping D to A.
  task automatic rd(logic [3:0] mask, int n);
    logic [1:0] ch;
    ch = (mask == 4'h2) ? 2'h1 : (mask == 4'h4) ? 2'h2 : (mask == 4'h8) ? 2'h3 : CH_A;
    mdl.start();
    wb({ADDR_FIXED, strapHi, strapLo, 1'b0});
    wb({CMD_NOP, mask});
    mdl.start();
    wb({ADDR_FIXED, strapHi, strapLo, 1'b1});
    for (int k = 0; k < 2*n; k++) begin
      busByte(8'hff, k == 2*n-1, {k[0] ? {expIn[ch][1:0], 6'h00} : expIn[ch][9:2], k == 2*n-1});
      if (k[0]) ch++;
    end
    mdl.stop();
  endtask : rd

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: every command code, power modes, readback, foreign addresses.
  initial begin
    #D rst = 1'b1;  // The serial-side capture flops clear only on a reset edge.
    repeat (12) @(posedge ref_clk);
    #D rst = 1'b0;
    for (int k = 0; k < 32; k++) begin
      r = rnd();
      @(posedge ref_clk);
      #D {strapHi, strapLo} = r[1:0];
      repeat (6) @(posedge ref_clk);
      wr({4'(k * 5), r[5:2]}, r[31:16]);
    end
    wr({CMD_POWER, 4'h0}, 16'h00e4);
    for (int i = 0; i < NUM_CH; i++) wr({CMD_WR_UPD, 4'(1 << i)}, 16'(rnd()));
    rd(4'h4, 6);
    rd(4'hf, 1);
    rd(4'h8, 2);
    for (int j = 0; j < 4; j++) begin
      r[7:0] = j == 0 ? 8'h00 : j == 1 ? 8'hf0 : j == 2 ? {ADDR_FIXED ^ 5'h10, strapHi, strapLo, 1'b0}
                                                      : {ADDR_FIXED, !strapHi, strapLo, 1'b0};
      mdl.start();
      busByte(r[7:0], 1'b1, {r[7:0], 1'b1});
      busByte(8'h34, 1'b1, {8'h34, 1'b1});
      mdl.stop();
    end
    chkState();
    results();
  end

  // Watchdog well beyond the expected run of roughly 300 us.
  initial begin
    #450us;
    mismatches++;
    results();
  end
endmodule : quad_dac_serial_command_port_tb

bind quad_dac_serial_command_port quad_dac_serial_command_port_properties chk_u (
  .ref_clk(ref_clk), .rst(rst), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .addressStrapHigh(addressStrapHigh), .addressStrapLow(addressStrapLow),
  .dacCode(dacCode), .inputCode(inputCode), .powerMode(powerMode), .ampConnect(ampConnect),
  .term1k(term1k), .term100k(term100k), .busSelected(busSelected));

// >>> scl_bit_capture.sv
`timescale 1ns/1ps
module scl_bit_capture
  import dac_port_pkg::*;
(
  input  wire logic sclClk,     // Serial clock from the bus master.
  input  wire logic rst,        // Reset, active high, applied without sclClk.
  input  wire logic sdaIn,      // Serial data line level.
  output logic      bitToggle,  // Flips once per rising serial clock edge.
  output logic      bitValue    // Data sampled at that edge, held a full period.
);

  typedef struct packed {
    logic tog;
    logic val;
  } cap_s;

  cap_s capReg;
  cap_s capNext;

  // Data is stable while the clock is high, so the rising edge is the
  // sampling point; the value holds until the next edge, which lets the
  // system side read it safely once it has seen the toggle.
  always_comb begin
    capNext     = capReg;
    capNext.tog = ~capReg.tog;
    capNext.val = sdaIn;
  end

  // The serial clock may stand still during reset, so reset cannot wait for it.
  always_ff @(posedge sclClk or posedge rst) begin
    if (rst) begin
      capReg <= '0;
    end else begin
      capReg <= capNext;
    end
  end

  assign bitToggle = capReg.tog;
  assign bitValue  = capReg.val;

endmodule : scl_bit_capture

// >>> sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff
  import dac_port_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,  // System clock.
  input  wire logic             rst,      // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] asyncIn,  // Levels from another domain.
  output logic      [WIDTH-1:0] syncOut   // Levels safe to use in ref_clk.
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s syncReg;
  sync_s syncNext;

  // Stage one only feeds stage two, so metastability never reaches logic.
  always_comb begin
    syncNext        = syncReg;
    syncNext.stage1 = asyncIn;
    syncNext.stage2 = syncReg.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg.stage2;

endmodule : sync_2ff

// >>> two_wire_master_model.sv
`timescale 1ns/1ps
module two_wire_master_model (
  output logic      sclClk,     // Serial clock, parked high between frames.
  output logic      sdaDrvLow,  // High while pulling data low.
  input  wire logic sdaWire     // Resolved data wire.
);
  localparam time Q = 40ns;

  // Both lines idle released; the pull-up holds data high.
  initial begin
    sclClk = 1'b1;
    sdaDrvLow = 1'b0;
  end

  // Start or repeated start: data falls while clock is high.
  task automatic start();
    #Q sdaDrvLow = 1'b0;
    #Q sclClk = 1'b1;
    #Q sdaDrvLow = 1'b1;
    #Q sclClk = 1'b0;
  endtask : start

  // Data moves mid-low, never at a clock edge, so no false start is seen.
  task automatic bitIo(input logic b, output logic r);
    #Q sdaDrvLow = !b;
    #Q sclClk = 1'b1;
    #Q r = sdaWire;
    #Q sclClk = 1'b0;
  endtask : bitIo

  task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                      output logic ackOut);
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(ackIn, ackOut);
  endtask : xfer

  task automatic stop();
    #Q sdaDrvLow = 1'b1;
    #Q sclClk = 1'b1;
    #Q sdaDrvLow = 1'b0;
  endtask : stop
endmodule : two_wire_master_model
